// ===== pkg/abs_pkg.sv
/*
 * Constants and types for the alternate boot selector: strap codes,
 * preset register values, signature addresses and the indicator map.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package abs_pkg;
    // ==========================================================
    // Strap decoding
    typedef enum logic [3:0] {
        ABS_MODE_NORMAL = 4'h1,
        ABS_MODE_BSL    = 4'h2,
        ABS_MODE_ALT    = 4'h4,
        ABS_MODE_TEST   = 4'h8
    } abs_mode_t;

    localparam logic [1:0] ABS_STRAP_ALT    = 2'h1;
    localparam logic [1:0] ABS_STRAP_BSL    = 2'h2;
    localparam logic [1:0] ABS_STRAP_NORMAL = 2'h3;

    // ==========================================================
    // Preset values
    localparam logic [15:0] ABS_SYSCFG_ALT    = 16'h0404;
    localparam logic [15:0] ABS_SYSCFG_RESET  = 16'h0000;
    localparam logic [15:0] ABS_XPSEL_ALT     = 16'h002d;
    localparam logic [15:0] ABS_XPSEL_RESET   = 16'h0000;
    localparam logic [15:0] ABS_CP_ALT        = 16'hfa00;
    localparam logic [15:0] ABS_STACK_UNDERFLOW_LIMIT_ALT     = 16'hfa00;
    localparam logic [15:0] ABS_SP_ALT        = 16'hfa40;
    localparam logic [15:0] ABS_STACK_OVERFLOW_LIMIT_ALT     = 16'hfc00;
    localparam logic [15:0] ABS_STK_RESET     = 16'h0000;
    localparam logic [15:0] ABS_BUSCFG_RESET  = 16'h0000;
    localparam int          ABS_FLASH_EN_BIT  = 10;
    localparam int          ABS_BYTE_DIS_BIT  = 9;
    localparam int          ABS_EXTENSION_PERIPH_ENABLE_BIT      = 2;
    localparam int          ABS_BUS_ACT_BIT   = 10;
    localparam int          ABS_LATCH_LEN_BIT = 9;
    localparam int          ABS_BUS_TYPE_FIELD_LO       = 6;

    // ==========================================================
    // Signature locations and start addresses (24-bit), reread values (16-bit)
    localparam logic [23:0] ABS_USR_OP0  = 24'h000000;
    localparam logic [23:0] ABS_USR_OP1  = 24'h001ffc;
    localparam logic [23:0] ABS_USR_REF  = 24'h001ffe;
    localparam logic [23:0] ABS_ALT_OP0  = 24'h090000;
    localparam logic [23:0] ABS_ALT_OP1  = 24'h091ffc;
    localparam logic [23:0] ABS_ALT_REF  = 24'h091ffe;
    localparam logic [23:0] ABS_VEC_BASE = 24'h000000;
    localparam logic [23:0] ABS_ALT_ENTRY = 24'h090000;
    localparam logic [15:0] ABS_SEL_ZERO = 16'h0000;
    localparam logic [15:0] ABS_SEL_ONES = 16'hffff;

    // Outcome of the boot sequence
    typedef enum logic [3:0] {
        ABS_GO_NONE   = 4'h0,
        ABS_GO_USER   = 4'h1,
        ABS_GO_ALTERN = 4'h2,
        ABS_GO_BSL    = 4'h4,
        ABS_GO_SELECT = 4'h8
    } abs_go_t;

    // ==========================================================
    // Register map
    localparam logic [15:0] ABS_ADDR_INDICATOR = 16'hfe0a;
    localparam logic [15:0] ABS_ADDR_SYSCFG    = 16'hff12;
    localparam logic [15:0] ABS_ADDR_XPSEL     = 16'hf024;
    localparam logic [15:0] ABS_ADDR_BUSCFG    = 16'hff0c;
    localparam logic [15:0] ABS_ADDR_STATUS    = 16'hfe0c;
    localparam int          ABS_ALT_FLAG_BIT   = 5;
endpackage

// ===== pkg/abs_flash_if.sv
/*
 * Flash read port between the selector and its signature checker.
 * Assumes one clock domain; read data arrive one cycle after the request.
 */
`timescale 1ns/1ps
`default_nettype none
interface abs_flash_if;
    logic        rd;
    logic [23:0] addr;
    logic [15:0] data;
    logic        start;
    logic        busy;
    abs_pkg::abs_go_t go;
    logic        done;
    modport chk (output rd, output addr, input data, input start,
                 output busy, output go, output done);
    modport top (input rd, input addr, output data, output start,
                 input busy, input go, input done);
endinterface
`default_nettype wire

// ===== rtl/abs_sig_check.sv
/*
 * Signature integrity checker: reads operand and reference words,
 * decides where execution continues after an alternate boot.
 * Assumes flash data one cycle after each read request.
 */
`timescale 1ns/1ps
`default_nettype none
module abs_sig_check (
    input  wire logic clk_in,    // Core clock
    input  wire logic nrst_in,   // Async reset, active low
    abs_flash_if.chk  fl         // Flash port and handshake
);
    import abs_pkg::*;

    typedef enum logic [3:0] {
        ABS_C_IDLE = 4'h1,
        ABS_C_REQ  = 4'h2,
        ABS_C_WAIT = 4'h4,
        ABS_C_DONE = 4'h8
    } abs_cst_t;

    abs_cst_t    st_q, st_d;
    logic [2:0]  idx_q, idx_d;
    logic [15:0] sum_q, sum_d;
    abs_go_t     go_q, go_d;
    logic [23:0] addr_c;
    logic [15:0] sig_c;

    // ==========================================================
    // Read sequence
    always_comb begin
        case (idx_q)
            3'h0:    addr_c = ABS_USR_OP0;
            3'h1:    addr_c = ABS_USR_OP1;
            3'h2:    addr_c = ABS_USR_REF;
            3'h3:    addr_c = ABS_ALT_OP0;
            3'h4:    addr_c = ABS_ALT_OP1;
            3'h5:    addr_c = ABS_ALT_REF;
            default: addr_c = ABS_USR_OP1;
        endcase
    end

    assign sig_c = {sum_q[15:8], ~sum_q[7:0]};

    always_comb begin
        st_d  = st_q;
        idx_d = idx_q;
        sum_d = sum_q;
        go_d  = go_q;
        case (st_q)
            // Done holds the outcome until the next alternate boot restarts it
            ABS_C_IDLE, ABS_C_DONE: begin
                if (fl.start) begin
                    st_d  = ABS_C_REQ;
                    idx_d = 3'h0;
                    go_d  = ABS_GO_NONE;
                end
            end
            ABS_C_REQ: st_d = ABS_C_WAIT;
            ABS_C_WAIT: begin
                st_d  = ABS_C_REQ;
                idx_d = idx_q + 3'h1;
                case (idx_q)
                    3'h0, 3'h3: sum_d = fl.data;
                    3'h1, 3'h4: sum_d = sum_q + fl.data;
                    3'h2: if (sig_c == fl.data) begin
                        go_d = ABS_GO_USER;
                        st_d = ABS_C_DONE;
                    end
                    3'h5: if (sig_c == fl.data) begin
                        go_d = ABS_GO_ALTERN;
                        st_d = ABS_C_DONE;
                    end
                    default: begin
                        st_d = ABS_C_DONE;
                        if (fl.data == ABS_SEL_ZERO || fl.data == ABS_SEL_ONES)
                            go_d = ABS_GO_BSL;
                        else
                            go_d = ABS_GO_SELECT;
                    end
                endcase
            end
            default:    st_d = ABS_C_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q  <= ABS_C_IDLE;
            idx_q <= 3'h0;
            sum_q <= 16'h0000;
            go_q  <= ABS_GO_NONE;
        end else begin
            st_q  <= st_d;
            idx_q <= idx_d;
            sum_q <= sum_d;
            go_q  <= go_d;
        end
    end

    assign fl.rd   = (st_q == ABS_C_REQ);
    assign fl.addr = addr_c;
    assign fl.busy = (st_q == ABS_C_REQ) || (st_q == ABS_C_WAIT);
    assign fl.done = (st_q == ABS_C_DONE);
    assign fl.go   = go_q;

    a_sig_order: assert property (@(posedge clk_in) disable iff (!nrst_in)
        fl.rd |-> ##1 (!fl.rd && fl.busy))
        else $error("flash read repeated back to back");
    a_done_outcome: assert property (@(posedge clk_in) disable iff (!nrst_in)
        fl.done |-> (fl.go != ABS_GO_NONE))
        else $error("check finished without an outcome");
endmodule
`default_nettype wire

// ===== rtl/abs_boot_sel.sv
/*
 * Boot mode selector: latches straps at reset release, decodes the mode,
 * presets system registers for alternate boot and runs the signature
 * check. Assumes straps, flash data and bus strobes synchronous to clk_in;
 * the external reset is seen as a synchronous level.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Straps latched at reset rising edge; 01 selects alternate boot
// - Code 11 runs an ordinary reset with no loader
// - Code 10 starts standard loader and clears the alternate flag
// - Any other code selects internal test modes
// - Bootstrap modes map test flash and vectors at address zero
// - First flash region never serves fetches; second region serves all
// - All interrupts held off during alternate boot
// - Alternate boot presets system config 0404 and peripheral select 002d
// - Context pointer, underflow fa00; stack pointer fa40; overflow fc00
// - Bootstrap forces flash enable bit 10; byte disable follows width strap
// - Bus config zero clear if access pin high, else bits 10,9, type strapped
// - Peripheral select and enable bit writable until end of init
// - Watchdog off in alternate boot; its reset becomes software reset
// - Alternate boot ends only by software or hardware reset
// - Valid alternate signature starts code at 09'0000
// - User signature uses 00'0000, 00'1ffc and reference 00'1ffe
// - Alternate signature uses 09'0000, 09'1ffc and reference 09'1ffe
// - Add operands, invert low byte, compare with reference
// - Alternate boot picks its reset sequence from signature results
// - Read-only alternate flag bit 5 at fe0a, set until next reset
// - No valid signature: reread 00'1ffc; 0000 or ffff go to loader
module abs_boot_sel (
    input  wire logic             clk_in,          // Core clock, 200 MHz
    input  wire logic             nrst_in,         // Async reset, active low
    input  wire logic             ext_reset_in,    // External reset input level
    input  wire logic [1:0]       config_port_low_in, // Mode straps
    input  wire logic             wide_bus_in,     // Data width strap
    input  wire logic [1:0]       bus_type_in,     // Bus type straps
    input  wire logic             external_access_pin_in, // External access level
    input  wire logic             sw_reset_in,     // Software reset pulse
    input  wire logic             wdt_reset_in,    // Watchdog reset request
    input  wire logic             end_of_init_in,  // End of init executed
    input  wire logic             fetch_in,        // Access is a code fetch
    input  wire logic             region_one_in,   // Access hits first flash
    input  wire logic [15:0]      flash_data_in,   // Flash read data
    input  wire logic [15:0]      addr_in,         // Register address
    input  wire logic [15:0]      wdata_in,        // Register write data
    input  wire logic             wr_in,           // Write strobe
    input  wire logic             rd_in,           // Read strobe
    output logic [15:0]           rdata_out,       // Read data
    output logic                  flash_rd_out,    // Flash read request
    output logic [23:0]           flash_addr_out,  // Flash read address
    output abs_pkg::abs_mode_t    mode_out,        // Decoded boot mode
    output abs_pkg::abs_go_t      go_out,          // Chosen reset sequence
    output logic [23:0]           start_addr_out,  // Execution start address
    output logic                  test_flash_map_out, // Test flash at zero
    output logic                  fetch_deny_out,  // Fetch refused
    output logic                  irq_enable_out,  // Interrupts allowed
    output logic                  wdt_enable_out,  // Watchdog allowed
    output logic                  sw_reset_out,    // Software reset request
    output logic                  hw_seq_out,      // Ordinary reset sequence
    output logic [15:0]           context_pointer_out, // Context pointer
    output logic [15:0]           stack_pointer_out,   // Stack pointer
    output logic [15:0]           stack_underflow_limit_out, // Underflow limit
    output logic [15:0]           stack_overflow_limit_out   // Overflow limit
);
    import abs_pkg::*;

    abs_flash_if fl ();

    // ==========================================================
    // Strap capture
    logic        rst_in_q;
    logic        latch_c;
    abs_mode_t   mode_q, mode_d;
    logic        alt_flag_q, alt_flag_d;
    logic        sw_rst_q, sw_rst_d;
    logic        start_q, start_d;

    assign latch_c = ext_reset_in && !rst_in_q;

    always_comb begin
        mode_d     = mode_q;
        alt_flag_d = alt_flag_q;
        start_d    = 1'b0;
        if (latch_c) begin
            case (config_port_low_in)
                ABS_STRAP_ALT: begin
                    mode_d     = ABS_MODE_ALT;
                    alt_flag_d = 1'b1;
                    start_d    = 1'b1;
                end
                ABS_STRAP_BSL: begin
                    mode_d     = ABS_MODE_BSL;
                    alt_flag_d = 1'b0;
                end
                ABS_STRAP_NORMAL: begin
                    mode_d     = ABS_MODE_NORMAL;
                    alt_flag_d = 1'b0;
                end
                default: begin
                    mode_d     = ABS_MODE_TEST;
                    alt_flag_d = 1'b0;
                end
            endcase
        end else if (sw_reset_in || sw_rst_q) begin
            // only a reset leaves alternate boot
            mode_d     = ABS_MODE_NORMAL;
            alt_flag_d = 1'b0;
        end
    end

    // watchdog reset turned into software reset
    assign sw_rst_d = wdt_reset_in && (mode_q == ABS_MODE_ALT);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            // Starts high: a strap latch needs a low phase after release
            rst_in_q   <= 1'b1;
            mode_q     <= ABS_MODE_NORMAL;
            alt_flag_q <= 1'b0;
            sw_rst_q   <= 1'b0;
            start_q    <= 1'b0;
        end else begin
            rst_in_q   <= ext_reset_in;
            mode_q     <= mode_d;
            alt_flag_q <= alt_flag_d;
            sw_rst_q   <= sw_rst_d;
            start_q    <= start_d;
        end
    end

    assign fl.start = start_q;
    assign fl.data  = flash_data_in;

    abs_sig_check u_chk (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .fl      (fl)
    );

    // ==========================================================
    // Presets and configuration registers
    logic [15:0] syscfg_q, syscfg_d;
    logic [15:0] xpsel_q, xpsel_d;
    logic [15:0] buscfg_q, buscfg_d;
    logic [15:0] cp_q, cp_d, sp_q, sp_d, stack_underflow_limit_q, stack_underflow_limit_d, stack_overflow_limit_q, stack_overflow_limit_d;
    logic        locked_q, locked_d;
    logic [15:0] rdata_d;
    logic        boot_c;
    abs_go_t     go_q;

    assign boot_c = (mode_d == ABS_MODE_ALT) || (mode_d == ABS_MODE_BSL);

    always_comb begin
        syscfg_d = syscfg_q;
        xpsel_d  = xpsel_q;
        buscfg_d = buscfg_q;
        cp_d     = cp_q;
        sp_d     = sp_q;
        stack_underflow_limit_d  = stack_underflow_limit_q;
        stack_overflow_limit_d  = stack_overflow_limit_q;
        locked_d = locked_q || end_of_init_in;
        if (latch_c) begin
            locked_d = 1'b0;
            syscfg_d = ABS_SYSCFG_RESET;
            xpsel_d  = ABS_XPSEL_RESET;
            if (mode_d == ABS_MODE_ALT) begin
                syscfg_d = ABS_SYSCFG_ALT;
                xpsel_d  = ABS_XPSEL_ALT;
                cp_d     = ABS_CP_ALT;
                stack_underflow_limit_d  = ABS_STACK_UNDERFLOW_LIMIT_ALT;
                sp_d     = ABS_SP_ALT;
                stack_overflow_limit_d  = ABS_STACK_OVERFLOW_LIMIT_ALT;
            end
            if (boot_c) begin
                syscfg_d[ABS_FLASH_EN_BIT] = 1'b1;
                syscfg_d[ABS_BYTE_DIS_BIT] = !wide_bus_in;
            end
            buscfg_d = ABS_BUSCFG_RESET;
            if (!external_access_pin_in) begin
                buscfg_d[ABS_BUS_ACT_BIT]   = 1'b1;
                buscfg_d[ABS_LATCH_LEN_BIT] = 1'b1;
                buscfg_d[ABS_BUS_TYPE_FIELD_LO +: 2]  = bus_type_in;
            end
        end else if (wr_in && !locked_q) begin
            if (addr_in == ABS_ADDR_XPSEL)
                xpsel_d = wdata_in;
            if (addr_in == ABS_ADDR_SYSCFG)
                syscfg_d[ABS_EXTENSION_PERIPH_ENABLE_BIT] = wdata_in[ABS_EXTENSION_PERIPH_ENABLE_BIT];
        end
        rdata_d = 16'h0000;
        if (rd_in) begin
            case (addr_in)
                ABS_ADDR_INDICATOR: rdata_d[ABS_ALT_FLAG_BIT] = alt_flag_q;
                ABS_ADDR_SYSCFG:    rdata_d = syscfg_q;
                ABS_ADDR_XPSEL:     rdata_d = xpsel_q;
                ABS_ADDR_BUSCFG:    rdata_d = buscfg_q;
                ABS_ADDR_STATUS:    rdata_d = {8'h00, go_q, mode_q};
                default:            rdata_d = 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // Output stage
    logic [23:0] start_addr_d;

    always_comb begin
        case (fl.go)
            ABS_GO_ALTERN: start_addr_d = ABS_ALT_ENTRY;  // entry
            default:       start_addr_d = ABS_VEC_BASE;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            syscfg_q  <= ABS_SYSCFG_RESET;
            xpsel_q   <= ABS_XPSEL_RESET;
            buscfg_q  <= ABS_BUSCFG_RESET;
            cp_q      <= ABS_STK_RESET;
            sp_q      <= ABS_STK_RESET;
            stack_underflow_limit_q   <= ABS_STK_RESET;
            stack_overflow_limit_q   <= ABS_STK_RESET;
            locked_q  <= 1'b0;
            rdata_out <= 16'h0000;
            go_q      <= ABS_GO_NONE;
            start_addr_out     <= ABS_VEC_BASE;
            flash_rd_out       <= 1'b0;
            flash_addr_out     <= ABS_USR_OP0;
            test_flash_map_out <= 1'b0;
            fetch_deny_out     <= 1'b0;
            irq_enable_out     <= 1'b1;
            wdt_enable_out     <= 1'b1;
            sw_reset_out       <= 1'b0;
            hw_seq_out         <= 1'b0;
        end else begin
            syscfg_q  <= syscfg_d;
            xpsel_q   <= xpsel_d;
            buscfg_q  <= buscfg_d;
            cp_q      <= cp_d;
            sp_q      <= sp_d;
            stack_underflow_limit_q   <= stack_underflow_limit_d;
            stack_overflow_limit_q   <= stack_overflow_limit_d;
            locked_q  <= locked_d;
            rdata_out <= rdata_d;
            go_q      <= fl.go;
            start_addr_out <= start_addr_d;
            flash_rd_out   <= fl.rd;
            flash_addr_out <= fl.addr;
            // test flash at zero in boot modes
            test_flash_map_out <= boot_c;
            fetch_deny_out <= fetch_in && region_one_in;
            irq_enable_out <= (mode_d != ABS_MODE_ALT);
            wdt_enable_out <= !boot_c;
            sw_reset_out   <= sw_rst_q;
            hw_seq_out     <= (mode_d == ABS_MODE_NORMAL);
        end
    end

    assign mode_out                  = mode_q;
    assign go_out                    = go_q;
    assign context_pointer_out       = cp_q;
    assign stack_pointer_out         = sp_q;
    assign stack_underflow_limit_out = stack_underflow_limit_q;
    assign stack_overflow_limit_out  = stack_overflow_limit_q;

    // ==========================================================
    // Checks
    a_alt_entry_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (latch_c && config_port_low_in == ABS_STRAP_ALT) |=> alt_flag_q)
        else $error("alternate strap did not set flag");
    a_bsl_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (latch_c && config_port_low_in == ABS_STRAP_BSL) |=> !alt_flag_q)
        else $error("loader strap left flag set");
    a_test_mode: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (latch_c && config_port_low_in == 2'h0) |=> mode_q == ABS_MODE_TEST)
        else $error("test strap not decoded");
    a_alt_presets: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (latch_c && config_port_low_in == ABS_STRAP_ALT) |=>
        (sp_q == ABS_SP_ALT && stack_overflow_limit_q == ABS_STACK_OVERFLOW_LIMIT_ALT && cp_q == ABS_CP_ALT))
        else $error("stack presets wrong");
    a_syscfg_lock: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (locked_q && !latch_c) |=> $stable(xpsel_q))
        else $error("peripheral select changed after lock");
    a_irq_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode_q == ABS_MODE_ALT) ##1 (mode_q == ABS_MODE_ALT) |-> !irq_enable_out)
        else $error("interrupts enabled in alternate boot");
    a_wdt_to_sw: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wdt_reset_in && mode_q == ABS_MODE_ALT) |-> ##2 sw_reset_out)
        else $error("watchdog reset not converted");
    a_fetch_deny: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (fetch_in && region_one_in) |=> fetch_deny_out)
        else $error("fetch from first region allowed");
    a_flag_ro: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_in && !latch_c && !sw_reset_in && !sw_rst_q) |=> $stable(alt_flag_q))
        else $error("flag changed by write");
    a_wdt_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (mode_q == ABS_MODE_ALT) |-> !wdt_enable_out)
        else $error("watchdog enabled in alternate boot");
    c_alt_boot: cover property (@(posedge clk_in) go_q == ABS_GO_ALTERN);
    c_user_boot: cover property (@(posedge clk_in) go_q == ABS_GO_USER);
    c_bsl_boot: cover property (@(posedge clk_in) go_q == ABS_GO_BSL);
    c_select_boot: cover property (@(posedge clk_in) go_q == ABS_GO_SELECT);
endmodule
`default_nettype wire

// ===== verif/abs_flash_model.sv
/* Flash array model answering signature reads of the selector.
   Assumes data due in the same cycle the read pulse is seen. */
`timescale 1ns/1ps
`default_nettype none
module abs_flash_model
    import abs_pkg::*;
(
    input  wire logic             clk_in,   // Core clock
    input  wire logic             rd_in,    // Read pulse
    input  wire logic [23:0]      addr_in,  // Word address
    input  wire logic [5:0][15:0] words_in, // Signature words
    output logic      [15:0]      data_out  // Read data
);
    // ==========================================
    // Array lookup
    logic [15:0] word, last_q;
    always_comb begin
        case (addr_in)
            ABS_USR_OP0: word = words_in[0];
            ABS_USR_OP1: word = words_in[1];
            ABS_USR_REF: word = words_in[2];
            ABS_ALT_OP0: word = words_in[3];
            ABS_ALT_OP1: word = words_in[4];
            ABS_ALT_REF: word = words_in[5];
            default:     word = ~last_q;
        endcase
    end
    // Idle bus shows the inverse, never a stale word
    assign data_out = rd_in ? word : ~last_q;
    always_ff @(posedge clk_in) if (rd_in) last_q <= word;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
/* Self-checking bench of the boot selector.
   Assumes the flash model and the design package are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import abs_pkg::*;
    // ==========================================
    // Signals
    logic clk_in = 0, nrst_in = 0, ext_r = 0, wide = 1, eap = 0, swr = 0, eoi = 0;
    logic fet = 0, reg1 = 0, wr = 0, rd = 0, frd, tfm, fdeny, irq, wdt, wdr = 0, swo, hseq;
    logic [1:0] strap = 3, bus_type_field = 0;
    logic [15:0] addr = 0, wd = 0, rdata, fdat, cp, sp, su, so, d;
    logic [23:0] faddr, start;
    logic [5:0][15:0] w = '0;
    abs_mode_t mode;
    abs_go_t go;
    int n_errors = 0, samples_checked = 0, k;
    always #2.5 clk_in = ~clk_in;
    abs_boot_sel dut (.clk_in, .nrst_in, .ext_reset_in(ext_r), .config_port_low_in(strap),
        .wide_bus_in(wide), .bus_type_in(bus_type_field), .external_access_pin_in(eap),
        .sw_reset_in(swr), .wdt_reset_in(wdr), .end_of_init_in(eoi), .fetch_in(fet),
        .region_one_in(reg1), .flash_data_in(fdat), .addr_in(addr), .wdata_in(wd),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .flash_rd_out(frd),
        .flash_addr_out(faddr), .mode_out(mode), .go_out(go), .start_addr_out(start),
        .test_flash_map_out(tfm), .fetch_deny_out(fdeny), .irq_enable_out(irq),
        .wdt_enable_out(wdt), .sw_reset_out(swo), .hw_seq_out(hseq),
        .context_pointer_out(cp), .stack_pointer_out(sp),
        .stack_underflow_limit_out(su), .stack_overflow_limit_out(so));
    abs_flash_model flash (.clk_in, .rd_in(frd), .addr_in(faddr), .words_in(w),
        .data_out(fdat));
    // ==========================================
    // Tasks
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wreg(logic [15:0] a, logic [15:0] v);
        @(posedge clk_in); addr <= a; wd <= v; wr <= 1;
        @(posedge clk_in); wr <= 0;
    endtask
    task automatic rreg(logic [15:0] a, output logic [15:0] v);
        @(posedge clk_in); addr <= a; rd <= 1;
        @(posedge clk_in); rd <= 0;
        #1 v = rdata;
    endtask
    task automatic boot(logic [1:0] s);
        @(posedge clk_in); strap <= s; ext_r <= 0; eap <= $urandom; bus_type_field <= $urandom;
        repeat (2) @(posedge clk_in); ext_r <= 1;
        repeat (3) @(posedge clk_in); #1;
    endtask
    // Expected outcome: user first, exact equality, then reread word
    function automatic abs_go_t exp_go(logic [5:0][15:0] v);
        if (v[2] === ((v[0] + v[1]) ^ 16'h00ff)) return ABS_GO_USER;
        if (v[5] === ((v[3] + v[4]) ^ 16'h00ff)) return ABS_GO_ALTERN;
        if (v[1] === 16'h0000 || v[1] === 16'hffff) return ABS_GO_BSL;
        return ABS_GO_SELECT;
    endfunction
    // ==========================================
    // Sequence
    initial begin
        void'($urandom(86));
        repeat (10) @(posedge clk_in);
        nrst_in <= 1;
        for (k = 0; k < 4; k++) begin
            boot(k[1:0]);
            chk("mode", mode, k == 1 ? ABS_MODE_ALT : k == 2 ? ABS_MODE_BSL : k == 3 ? ABS_MODE_NORMAL : ABS_MODE_TEST);
            chk("hw_seq", hseq, k == 3);
            rreg(ABS_ADDR_INDICATOR, d);
            chk("flag", d[5], k == 1);
        end
        for (k = 0; k < 12; k++) begin
            for (int j = 0; j < 6; j++) w[j] = $urandom;
            if (k % 4 == 0) w[2] = (w[0] + w[1]) ^ 16'h00ff;
            if (k % 4 == 1) w[5] = (w[3] + w[4]) ^ 16'h00ff;
            if (k % 4 == 2) w[1] = k[3] ? 16'hffff : 16'h0000;
            boot(ABS_STRAP_ALT);
            chk("cp", {cp, sp, su, so}, {ABS_CP_ALT, ABS_SP_ALT, ABS_STACK_UNDERFLOW_LIMIT_ALT, ABS_STACK_OVERFLOW_LIMIT_ALT});
            chk("irq_wdt_map", {irq, wdt, tfm}, 3'h1);
            for (int i = 0; go === ABS_GO_NONE; i++) begin
                if (i > 200) begin n_errors++; conclude(); end
                @(posedge clk_in); #1;
            end
            chk("go", go, exp_go(w));
            chk("start", start, exp_go(w) == ABS_GO_ALTERN ? ABS_ALT_ENTRY : ABS_VEC_BASE);
        end
        rreg(ABS_ADDR_SYSCFG, d);
        chk("syscfg", d, ABS_SYSCFG_ALT);
        rreg(ABS_ADDR_XPSEL, d);
        chk("xpsel_preset", d, ABS_XPSEL_ALT);
        rreg(ABS_ADDR_BUSCFG, d);
        chk("buscfg", d, eap ? ABS_BUSCFG_RESET : 16'h0600 | bus_type_field << ABS_BUS_TYPE_FIELD_LO);
        // stands in for a routine run from dual port RAM
        wreg(ABS_ADDR_XPSEL, 16'h0012);
        wreg(ABS_ADDR_INDICATOR, 16'h0000);
        rreg(ABS_ADDR_XPSEL, d);
        chk("xpsel", d, 16'h0012);
        rreg(ABS_ADDR_INDICATOR, d);
        chk("flag_ro", d[5], 1'b1);
        @(posedge clk_in); eoi <= 1; fet <= 1; reg1 <= 1;
        @(posedge clk_in); eoi <= 0; fet <= 0;
        #1 chk("deny", fdeny, 1'b1);
        @(posedge clk_in); #1 chk("deny_off", fdeny, 1'b0);
        wreg(ABS_ADDR_XPSEL, 16'h0033);
        rreg(ABS_ADDR_XPSEL, d);
        chk("locked", d, 16'h0012);
        chk("mode_kept", mode, ABS_MODE_ALT);
        @(posedge clk_in); swr <= 1;
        @(posedge clk_in); swr <= 0;
        @(posedge clk_in); #1 chk("exit", mode, ABS_MODE_NORMAL);
        boot(ABS_STRAP_ALT);
        @(posedge clk_in); wdr <= 1;
        @(posedge clk_in); wdr <= 0;
        @(posedge clk_in); #1 chk("wdt_sw", {swo, mode}, {1'b1, ABS_MODE_NORMAL});
        conclude();
    end
endmodule
`default_nettype wire
